// File: rtl/psg_guard.sv
// program store write and erase guard with wishbone register slave
`timescale 1ns/10ps
module psg_guard
    import psg_pkg::*;
(
    input  wire logic                  mclk_in,
    input  wire logic                  rstn_in,
    input  wire logic                  wb_cyc_in,
    input  wire logic                  wb_stb_in,
    input  wire logic                  wb_we_in,
    input  wire logic [7:0]            wb_adr_in,
    input  wire logic [3:0]            wb_sel_in,
    input  wire logic [31:0]           wb_dat_in,
    output logic      [31:0]           wb_dat_out,
    output logic                       wb_ack_out,
    input  wire logic                  xwr_in,
    input  wire logic [PSG_ADDR_W-1:0] xwr_addr_in,
    input  wire logic [7:0]            xwr_data_in,
    input  wire logic                  flash_done_in,
    output logic                       flash_prog_out,
    output logic                       flash_erase_out,
    output logic      [PSG_ADDR_W-1:0] flash_addr_out,
    output logic      [7:0]            flash_data_out,
    output logic                       xram_wr_out,
    output logic      [PSG_ADDR_W-1:0] xram_addr_out,
    output logic      [7:0]            xram_data_out,
    output logic                       flash_error_device_reset_out,
    output logic                       irq_out
);

    // ****************************************************************
    // reset synchroniser
    // ****************************************************************
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ****************************************************************
    // bus decode
    // ****************************************************************
    function automatic logic [7:0] lane0(input logic [31:0] d,
                                         input logic [3:0]  s,
                                         input logic [7:0]  old);
        lane0 = s[0] ? d[7:0] : old;
    endfunction

    logic        ack_q;
    logic [31:0] rdata_q;
    wire         bus_req  = wb_cyc_in & wb_stb_in & ~ack_q;
    wire         bus_wr   = bus_req & wb_we_in & wb_sel_in[0];
    wire         hit_ctrl = wb_adr_in == PSG_PROGRAM_STORE_CONTROL_OFS;
    wire         hit_key  = wb_adr_in == PSG_FLASH_LOCK_KEY_OFS;
    wire         hit_ists = wb_adr_in == PSG_IRQ_STATUS_OFS;
    wire         hit_imsk = wb_adr_in == PSG_IRQ_MASK_OFS;
    wire         hit_sup  = wb_adr_in == PSG_SUPPLY_CTRL_OFS;
    wire         hit_rsrc = wb_adr_in == PSG_RESET_SOURCE_OFS;
    wire [7:0]   wbyte    = lane0(wb_dat_in, wb_sel_in, 8'h00);
    wire         wr_ctrl  = bus_wr & hit_ctrl;
    wire         wr_key   = bus_wr & hit_key;
    wire         wr_ists  = bus_wr & hit_ists;
    wire         wr_imsk  = bus_wr & hit_imsk;
    wire         wr_sup   = bus_wr & hit_sup;
    wire         wr_rsrc  = bus_wr & hit_rsrc;

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [1:0] ctrl_q;
    logic [1:0] sup_q;
    logic [3:0] ists_q;
    logic [3:0] imsk_q;
    logic       ferr_q;
    logic [1:0] key_state;
    logic       lock_evt;
    psg_op_t    op_q;
    logic [3:0] flash_error_device_reset_cnt_q;

    wire we_on   = ctrl_q[PSG_WE_BIT];
    wire ee_on   = ctrl_q[PSG_EE_BIT];
    wire sup_ok  = sup_q[PSG_MON_EN_BIT] & sup_q[PSG_MON_RST_EN_BIT];
    wire is_idle = op_q == PSG_IDLE;

    // a data write is claimed by the flash only while write enable is set
    wire fl_try   = xwr_in & we_on & is_idle;
    wire fl_go    = fl_try & sup_ok & (key_state == PSG_ST_UNLOCKED);
    wire fl_erase = fl_go & ee_on;
    wire fl_prog  = fl_go & ~ee_on;
    wire flash_error_device_reset_go  = fl_try & ~sup_ok;
    wire op_done  = (op_q == PSG_BUSY) & flash_done_in;
    wire [PSG_ADDR_W-1:0] page_base =
        {xwr_addr_in[PSG_ADDR_W-1:PSG_PAGE_BITS], {PSG_PAGE_BITS{1'b0}}};

    // ****************************************************************
    // key sequencer
    // ****************************************************************
    psg_key_fsm u_key (
        .clk_in       (mclk_in),
        .rst_n_in     (rst_n_q),
        .key_wr_in    (wr_key),
        .key_data_in  (wbyte),
        .op_try_in    (fl_try & sup_ok),
        .op_done_in   (op_done),
        .state_out    (key_state),
        .lock_evt_out (lock_evt)
    );

    // ****************************************************************
    // operation sequencer
    // ****************************************************************
    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            op_q       <= PSG_IDLE;
            flash_error_device_reset_cnt_q <= 4'h0;
        end else begin
            case (op_q)
                PSG_IDLE: begin
                    if (flash_error_device_reset_go) begin
                        op_q       <= PSG_FERR;
                        flash_error_device_reset_cnt_q <= 4'(PSG_FLASH_ERROR_DEVICE_RESET_CYCLES - 1);
                    end else if (fl_go) begin
                        op_q <= PSG_BUSY;
                    end
                end
                PSG_BUSY: begin
                    if (flash_done_in) begin
                        op_q <= PSG_IDLE;
                    end
                end
                PSG_FERR: begin
                    if (flash_error_device_reset_cnt_q != 4'h0) begin
                        flash_error_device_reset_cnt_q <= flash_error_device_reset_cnt_q - 4'h1;
                    end
                end
                default: op_q <= PSG_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // flash strobes and operands
    // ****************************************************************
    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            flash_prog_out  <= 1'b0;
            flash_erase_out <= 1'b0;
        end else begin
            flash_prog_out  <= fl_prog;
            flash_erase_out <= fl_erase;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            flash_addr_out <= '0;
            flash_data_out <= 8'h00;
        end else if (fl_erase) begin
            flash_addr_out <= page_base;
            flash_data_out <= 8'hff;
        end else if (fl_prog) begin
            flash_addr_out <= xwr_addr_in;
            flash_data_out <= xwr_data_in;
        end
    end

    // ****************************************************************
    // external data forwarding
    // ****************************************************************
    wire xram_fwd = xwr_in & ~we_on;

    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            xram_wr_out   <= 1'b0;
            xram_addr_out <= '0;
            xram_data_out <= 8'h00;
        end else begin
            xram_wr_out <= xram_fwd;
            if (xram_fwd) begin
                xram_addr_out <= xwr_addr_in;
                xram_data_out <= xwr_data_in;
            end
        end
    end

    // ****************************************************************
    // flash error reset request
    // ****************************************************************
    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            flash_error_device_reset_out <= 1'b0;
        end else begin
            flash_error_device_reset_out <= (op_q == PSG_FERR);
        end
    end

    // ****************************************************************
    // software registers and interrupts
    // ****************************************************************
    logic [3:0] ev;
    logic [3:0] ists_clr;
    assign ev       = {flash_error_device_reset_go, lock_evt, fl_erase, fl_prog};
    assign ists_clr = wr_ists ? wbyte[3:0] : 4'h0;

    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= PSG_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= wbyte[1:0];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sup_q <= PSG_SUPPLY_RESET;
        end else if (wr_sup) begin
            sup_q <= wbyte[1:0];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            imsk_q <= PSG_IRQ_RESET;
        end else if (wr_imsk) begin
            imsk_q <= wbyte[3:0];
        end
    end

    // an event in the cycle of a clear keeps its bit set
    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ists_q <= PSG_IRQ_RESET;
        end else begin
            ists_q <= (ists_q & ~ists_clr) | ev;
        end
    end

    // flash error flag survives the error reset it reports
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ferr_q <= 1'b0;
        end else if (flash_error_device_reset_out) begin
            ferr_q <= 1'b1;
        end else if (wr_rsrc & wbyte[PSG_FERR_BIT]) begin
            ferr_q <= 1'b0;
        end
    end

    wire [7:0] rd_mux =
        hit_ctrl ? {6'h00, ctrl_q} :
        hit_key  ? {6'h00, key_state} :
        hit_ists ? {4'h0, ists_q} :
        hit_imsk ? {4'h0, imsk_q} :
        hit_sup  ? {6'h00, sup_q} :
        hit_rsrc ? {7'h00, ferr_q} : 8'h00;

    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= bus_req;
            rdata_q <= bus_req ? {24'h000000, rd_mux} : 32'h0000_0000;
        end
    end

    // ****************************************************************
    // interrupt output
    // ****************************************************************
    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(ists_q & imsk_q);
        end
    end

    assign wb_ack_out = ack_q;
    assign wb_dat_out = rdata_q;

endmodule // psg_guard

// File: include/psg_pkg.sv
// package: register map, key codes, field layout and timing of the guard
package psg_pkg;

    // ****************************************************************
    // wishbone register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] PSG_PROGRAM_STORE_CONTROL_OFS = 8'h8f;
    localparam logic [7:0] PSG_FLASH_LOCK_KEY_OFS        = 8'hb7;
    localparam logic [7:0] PSG_IRQ_STATUS_OFS            = 8'hc0;
    localparam logic [7:0] PSG_IRQ_MASK_OFS              = 8'hc4;
    localparam logic [7:0] PSG_SUPPLY_CTRL_OFS           = 8'hc8;
    localparam logic [7:0] PSG_RESET_SOURCE_OFS          = 8'hcc;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int         PSG_WE_BIT          = 0;
    localparam int         PSG_EE_BIT          = 1;
    localparam int         PSG_MON_EN_BIT      = 0;
    localparam int         PSG_MON_RST_EN_BIT  = 1;
    localparam int         PSG_FERR_BIT        = 0;
    localparam logic [1:0] PSG_CTRL_RESET      = 2'h0;
    localparam logic [1:0] PSG_SUPPLY_RESET    = 2'h3;
    localparam logic [3:0] PSG_IRQ_RESET       = 4'h0;

    // irq status bits
    localparam int         PSG_IRQ_WRITE_BIT   = 0;
    localparam int         PSG_IRQ_ERASE_BIT   = 1;
    localparam int         PSG_IRQ_LOCK_BIT    = 2;
    localparam int         PSG_IRQ_FLASH_ERROR_DEVICE_RESET_BIT    = 3;

    // ****************************************************************
    // key codes and lock states
    // ****************************************************************
    localparam logic [7:0] PSG_KEY_FIRST  = 8'ha5;
    localparam logic [7:0] PSG_KEY_SECOND = 8'hf1;
    localparam logic [1:0] PSG_ST_LOCKED   = 2'h0;
    localparam logic [1:0] PSG_ST_FIRST    = 2'h1;
    localparam logic [1:0] PSG_ST_UNLOCKED = 2'h2;
    localparam logic [1:0] PSG_ST_DISABLED = 2'h3;

    // ****************************************************************
    // flash geometry and timing
    // ****************************************************************
    localparam int         PSG_ADDR_W      = 16;
    localparam int         PSG_PAGE_BITS   = 9;
    localparam int         PSG_CLK_MHZ     = 125;
    localparam int         PSG_FLASH_ERROR_DEVICE_RESET_PULSE_NS = 64;
    localparam int         PSG_FLASH_ERROR_DEVICE_RESET_CYCLES =
        (PSG_FLASH_ERROR_DEVICE_RESET_PULSE_NS * PSG_CLK_MHZ + 999) / 1000;

    typedef enum logic [2:0] {
        PSG_IDLE = 3'h1,
        PSG_BUSY = 3'h2,
        PSG_FERR = 3'h4
    } psg_op_t;

endpackage

// File: rtl/psg_key_fsm.sv
// key sequencer: tracks the two-byte unlock and the permanent lock
`timescale 1ns/10ps
module psg_key_fsm
    import psg_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       key_wr_in,
    input  wire logic [7:0] key_data_in,
    input  wire logic       op_try_in,
    input  wire logic       op_done_in,
    output logic      [1:0] state_out,
    output logic            lock_evt_out
);

    logic [1:0] state_q;
    logic [1:0] state_d;
    logic       lock_d;
    logic       lock_q;

    // ****************************************************************
    // next lock state
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        lock_d  = 1'b0;
        if (state_q != PSG_ST_DISABLED) begin
            if (key_wr_in) begin
                if (state_q == PSG_ST_LOCKED &&
                    key_data_in == PSG_KEY_FIRST) begin
                    state_d = PSG_ST_FIRST;
                end else if (state_q == PSG_ST_FIRST &&
                    key_data_in == PSG_KEY_SECOND) begin
                    state_d = PSG_ST_UNLOCKED;
                end else begin
                    state_d = PSG_ST_DISABLED;
                    lock_d  = 1'b1;
                end
            end else if (op_try_in && state_q != PSG_ST_UNLOCKED) begin
                state_d = PSG_ST_DISABLED;
                lock_d  = 1'b1;
            end else if (op_done_in) begin
                state_d = PSG_ST_LOCKED;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= PSG_ST_LOCKED;
            lock_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            lock_q  <= lock_d;
        end
    end

    assign state_out    = state_q;
    assign lock_evt_out = lock_q;

endmodule // psg_key_fsm

// File: verif/psg_guard_properties.sv
// checker: port level properties of the program store guard
`timescale 1ns/10ps
module psg_guard_properties
    import psg_pkg::*;
(
    input wire logic                  mclk_in,
    input wire logic                  rstn_in,
    input wire logic                  wb_cyc_in,
    input wire logic                  wb_stb_in,
    input wire logic                  wb_ack_out,
    input wire logic                  xwr_in,
    input wire logic [PSG_ADDR_W-1:0] xwr_addr_in,
    input wire logic [7:0]            xwr_data_in,
    input wire logic                  flash_prog_out,
    input wire logic                  flash_erase_out,
    input wire logic [PSG_ADDR_W-1:0] flash_addr_out,
    input wire logic [7:0]            flash_data_out,
    input wire logic                  xram_wr_out,
    input wire logic [PSG_ADDR_W-1:0] xram_addr_out,
    input wire logic [7:0]            xram_data_out,
    input wire logic                  flash_error_device_reset_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    wire op_w = flash_prog_out || flash_erase_out;
    sequence s_copied;
        $past(xwr_in) && flash_addr_out == $past(xwr_addr_in);
    endsequence
    sequence s_flash_error_device_reset_hold;
        flash_error_device_reset_out [*7];
    endsequence
    a_bus_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
        |=> wb_ack_out) else $error("request not acknowledged");
    a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    a_prog_copy: assert property (flash_prog_out |-> s_copied ##0
        flash_data_out == $past(xwr_data_in)) else $error("bad program");
    a_erase_page: assert property (flash_erase_out |->
        $past(xwr_in) && flash_data_out == 8'hff &&
        flash_addr_out == ($past(xwr_addr_in) & 16'hfe00))
        else $error("bad page erase");
    a_op_excl: assert property (!(flash_prog_out && flash_erase_out))
        else $error("program and erase together");
    a_one_op: assert property (op_w |=> (!op_w) [*3])
        else $error("second operation without new key");
    a_xram_fwd: assert property (xram_wr_out |-> $past(xwr_in) &&
        !op_w && xram_addr_out == $past(xwr_addr_in) &&
        xram_data_out == $past(xwr_data_in)) else $error("bad forward");
    a_flash_error_device_reset_hold: assert property ($rose(flash_error_device_reset_out)
        |=> s_flash_error_device_reset_hold) else $error("error reset too short");
    a_flash_error_device_reset_no_op: assert property ($rose(flash_error_device_reset_out)
        |-> !op_w && $past(xwr_in, 2))
        else $error("error reset without cause");
endmodule // psg_guard_properties

bind psg_guard psg_guard_properties u_props (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .xwr_in(xwr_in),
    .xwr_addr_in(xwr_addr_in), .xwr_data_in(xwr_data_in),
    .flash_prog_out(flash_prog_out), .flash_erase_out(flash_erase_out),
    .flash_addr_out(flash_addr_out), .flash_data_out(flash_data_out),
    .xram_wr_out(xram_wr_out), .xram_addr_out(xram_addr_out),
    .xram_data_out(xram_data_out),
    .flash_error_device_reset_out(flash_error_device_reset_out)
);

// File: verif/psg_core_model.sv
// partner: core external data writes and flash macro completion
`timescale 1ns/10ps
module psg_core_model
    import psg_pkg::*;
#(
    parameter int DONE_LAT = 4
)(
    input  wire logic                  clk_in,
    input  wire logic                  flash_prog_in,
    input  wire logic                  flash_erase_in,
    input  wire logic                  xram_wr_in,
    output logic                       xwr_out,
    output logic      [PSG_ADDR_W-1:0] xwr_addr_out,
    output logic      [7:0]            xwr_data_out,
    output logic                       flash_done_out
);
    int prog_n  = 0;
    int erase_n = 0;
    int xram_n  = 0;
    int busy_q  = 0;
    initial begin
        xwr_out = 1'b0;
        xwr_addr_out = 16'h0;
        xwr_data_out = 8'h0;
        flash_done_out = 1'b0;
    end
    // one write strobe; address and data inverted once released
    task automatic mov(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        xwr_out <= 1'b1;
        xwr_addr_out <= a;
        xwr_data_out <= d;
        @(posedge clk_in);
        xwr_out <= 1'b0;
        xwr_addr_out <= ~a;
        xwr_data_out <= ~d;
    endtask
    always @(posedge clk_in) begin
        prog_n <= prog_n + int'(flash_prog_in);
        erase_n <= erase_n + int'(flash_erase_in);
        xram_n <= xram_n + int'(xram_wr_in);
        busy_q <= (flash_prog_in || flash_erase_in) ? DONE_LAT :
                  (busy_q > 0) ? busy_q - 1 : 0;
        flash_done_out <= (busy_q == 1);
    end
endmodule // psg_core_model

// File: verif/tb_program_store_write_erase_guard.sv
// testbench: registers, key sequence, flash operations and interrupt
`timescale 1ns/10ps
module tb_program_store_write_erase_guard;
    import psg_pkg::*;
    logic        mclk_in, rstn_in, cyc, stb, we, ack, xwr, done, prog, ers;
    logic        xram_wr, flash_error_device_reset, irq;
    logic [7:0]  adr, xdat, fdat, rdat;
    logic [31:0] dat, dat_o, r;
    logic [15:0] xadr, fadr, radr;
    int          failures  = 0;
    int          cmp_count = 0;
    localparam logic [7:0] C = PSG_PROGRAM_STORE_CONTROL_OFS;
    localparam logic [7:0] K = PSG_FLASH_LOCK_KEY_OFS;
    psg_guard u_dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(4'h1), .wb_dat_in(dat), .wb_dat_out(dat_o),
        .wb_ack_out(ack), .xwr_in(xwr), .xwr_addr_in(xadr),
        .xwr_data_in(xdat), .flash_done_in(done), .flash_prog_out(prog),
        .flash_erase_out(ers), .flash_addr_out(fadr),
        .flash_data_out(fdat), .xram_wr_out(xram_wr),
        .xram_addr_out(radr), .xram_data_out(rdat),
        .flash_error_device_reset_out(flash_error_device_reset), .irq_out(irq));
    psg_core_model u_core (.clk_in(mclk_in), .flash_prog_in(prog),
        .flash_erase_in(ers), .xram_wr_in(xram_wr), .xwr_out(xwr),
        .xwr_addr_out(xadr), .xwr_data_out(xdat), .flash_done_out(done));
    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_in);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do begin
            @(posedge mclk_in);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = dat_o;
        {cyc, stb} <= 2'b00;
        if (n >= 50) begin
            failures++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, {24'h0, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    task automatic cpu(input logic [15:0] a, input logic [7:0] d,
                       input logic [23:0] e);
        u_core.mov(a, d);
        repeat (10) @(posedge mclk_in);
        chk({8'h0, 8'(u_core.prog_n), 8'(u_core.erase_n),
             8'(u_core.xram_n)}, {8'h0, e});
    endtask
    task automatic unlock(input logic [7:0] ctl);
        wr(K, PSG_KEY_FIRST);
        wr(K, PSG_KEY_SECOND);
        wr(C, ctl);
    endtask
    task automatic rst();
        rstn_in <= 1'b0;
        repeat (10) @(posedge mclk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
    endtask
    initial begin
        {rstn_in, cyc, stb, we, adr, dat} = '0;
        rst();
        rd(C, 32'h0);
        rd(K, 32'h0);
        rd(PSG_SUPPLY_CTRL_OFS, 32'h3);
        rd(PSG_RESET_SOURCE_OFS, 32'h0);
        rd(8'h10, 32'h0);
        wr(C, 8'hff);
        rd(C, 32'h3);
        wr(C, 8'h00);
        cpu(16'h1234, 8'h5a, 24'h000001);
        chk({8'h0, radr, rdat}, 32'h0012_345a);
        wr(K, PSG_KEY_FIRST);
        rd(K, 32'h1);
        wr(K, PSG_KEY_SECOND);
        rd(K, 32'h2);
        wr(C, 8'h02);
        cpu(16'h0400, 8'h00, 24'h000002);
        rd(K, 32'h2);
        wr(C, 8'h03);
        cpu(16'h0433, 8'h3c, 24'h000102);
        chk({8'h0, fadr, fdat}, 32'h0004_00ff);
        rd(K, 32'h0);
        unlock(8'h01);
        cpu(16'h0433, 8'h96, 24'h010102);
        chk({8'h0, fadr, fdat}, 32'h0004_3396);
        rd(K, 32'h0);
        rd(PSG_IRQ_STATUS_OFS, 32'h3);
        wr(PSG_IRQ_MASK_OFS, 8'h02);
        repeat (2) @(posedge mclk_in);
        chk({31'h0, irq}, 32'h1);
        wr(PSG_IRQ_STATUS_OFS, 8'h02);
        repeat (2) @(posedge mclk_in);
        chk({31'h0, irq}, 32'h0);
        cpu(16'h0500, 8'h11, 24'h010102);
        rd(K, 32'h3);
        rd(PSG_IRQ_STATUS_OFS, 32'h5);
        unlock(8'h01);
        rd(K, 32'h3);
        cpu(16'h0501, 8'h22, 24'h010102);
        rst();
        wr(K, 8'h00);
        rd(K, 32'h3);
        rst();
        wr(PSG_SUPPLY_CTRL_OFS, 8'h01);
        unlock(8'h01);
        cpu(16'h0600, 8'h33, 24'h010102);
        chk({31'h0, flash_error_device_reset}, 32'h1);
        rd(PSG_RESET_SOURCE_OFS, 32'h1);
        rd(PSG_IRQ_STATUS_OFS, 32'h8);
        // the standing reset request wins over the clear
        wr(PSG_RESET_SOURCE_OFS, 8'h01);
        rd(PSG_RESET_SOURCE_OFS, 32'h1);
        rst();
        rd(PSG_RESET_SOURCE_OFS, 32'h0);
        end_of_test();
    end
endmodule // tb_program_store_write_erase_guard
